// ---- dacl_pkg.sv ----
// shared types and timing constants for the converter latch port host
package dacl_pkg;

  // ****************************************
  // data layout
  // ****************************************
  localparam int DACL_CODE_W = 12;
  localparam int DACL_NIB_W = 4;
  localparam int DACL_HI_LSB = 8;
  localparam int DACL_MID_LSB = 4;
  localparam int DACL_LO_LSB = 0;
  localparam logic [DACL_CODE_W-1:0] DACL_CODE_RST = 12'h000;

  // ****************************************
  // strobe timing
  // ****************************************
  localparam int DACL_CLK_MHZ = 250;
  localparam int DACL_SETUP_NS = 20;
  localparam int DACL_WR_LOW_NS = 60;
  localparam int DACL_HOLD_NS = 20;
  // least times, rounded up to whole cycles
  localparam int DACL_SETUP_CYC = (DACL_SETUP_NS * DACL_CLK_MHZ + 999) / 1000;
  localparam int DACL_WR_LOW_CYC = (DACL_WR_LOW_NS * DACL_CLK_MHZ + 999) / 1000;
  localparam int DACL_HOLD_CYC = (DACL_HOLD_NS * DACL_CLK_MHZ + 999) / 1000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    DACL_NIB4,
    DACL_BYTE_R,
    DACL_BYTE_L,
    DACL_WIDE
  } dacl_mode_e;

  // latch selects and last-write flag of one write, active high inside the host
  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
    logic load;
    logic last;
  } dacl_step_s;

  typedef struct packed {
    logic update_all;
    logic defer;
    logic [3:0] chan;
    logic [DACL_CODE_W-1:0] code;
  } dacl_cmd_s;

endpackage : dacl_pkg

// ---- dacl_strobe.sv ----
// write strobe generator: setup, low phase, hold, then a done pulse
module dacl_strobe
  import dacl_pkg::*;
#(
  parameter int SETUP_CYC = DACL_SETUP_CYC,
  parameter int LOW_CYC = DACL_WR_LOW_CYC,
  parameter int HOLD_CYC = DACL_HOLD_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic wr_n,
  output logic done
);

  typedef enum logic [1:0] {
    SP_IDLE,
    SP_SETUP,
    SP_LOW,
    SP_HOLD
  } dacl_sphase_e;

  if (SETUP_CYC < 1 || LOW_CYC < 1 || HOLD_CYC < 1 || LOW_CYC > 255 || SETUP_CYC > 255 || HOLD_CYC > 255) begin : g_chk
    $error("dacl_strobe: phase counts must lie in 1..255");
  end

  dacl_sphase_e phase_r;
  logic [7:0] cnt_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r <= SP_IDLE;
      cnt_r <= 8'h00;
      wr_n <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_r)
        SP_IDLE: begin
          if (start) begin
            phase_r <= SP_SETUP;
            cnt_r <= 8'(SETUP_CYC - 1);
          end
        end
        SP_SETUP: begin
          if (cnt_r == 8'h00) begin
            phase_r <= SP_LOW;
            cnt_r <= 8'(LOW_CYC - 1);
            wr_n <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        SP_LOW: begin
          if (cnt_r == 8'h00) begin
            phase_r <= SP_HOLD;
            cnt_r <= 8'(HOLD_CYC - 1);
            wr_n <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        SP_HOLD: begin
          if (cnt_r == 8'h00) begin
            phase_r <= SP_IDLE;
            done <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: phase_r <= SP_IDLE;
      endcase
    end
  end

endmodule : dacl_strobe

// ---- dacl_host.sv ----
// host that loads one or more double-buffered converter latch ports
// Operation
// - strobe built from select and write
// - load inputs first, shared transfer updates all
// - nibble bus: four selects per converter
// - nibble bus: write strobe drives directly
// - byte bus: two writes per code
// - low select bits pick latches per converter
// - right-justified: low byte, then high plus transfer
// - left-justified: high byte, then low nibble plus transfer
// - several converters: two slots each
// - extra slot transfers all converters together
// - last converter's low write transfers all
// - wide bus: nibble enables held low
// - wide bus: single strobe loads converter latch
module dacl_host
  import dacl_pkg::*;
#(
  parameter int NUM_DAC = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire dacl_mode_e mode,
  input wire logic last_loads_all,
  input wire logic cmd_valid,
  input wire dacl_cmd_s cmd,
  output logic cmd_ready,
  output logic [DACL_CODE_W-1:0] dac_data,
  output logic wr_n,
  output logic [NUM_DAC-1:0] nib_hi_n,
  output logic [NUM_DAC-1:0] nib_mid_n,
  output logic [NUM_DAC-1:0] nib_lo_n,
  output logic [NUM_DAC-1:0] converter_latch_load_n
);

  if (NUM_DAC < 1 || NUM_DAC > 16) begin : g_chk
    $error("dacl_host: NUM_DAC must lie in 1..16");
  end

  // ****************************************
  // write sequences per bus arrangement
  // ****************************************
  function automatic dacl_step_s step_ctl(input dacl_mode_e m, input logic [1:0] s, input logic defer);
    dacl_step_s r;
    r = '0;
    case (m)
      DACL_NIB4: begin
        r.hi = (s == 2'h0);
        r.mid = (s == 2'h1);
        r.lo = (s == 2'h2);
        r.load = (s == 2'h3);
        r.last = defer ? (s == 2'h2) : (s == 2'h3);
      end
      // low byte, then high nibble with transfer
      DACL_BYTE_R: begin
        r.mid = (s == 2'h0);
        r.lo = (s == 2'h0);
        r.hi = (s == 2'h1);
        r.load = (s == 2'h1) && !defer;
        r.last = (s == 2'h1);
      end
      // high byte, then low nibble with transfer
      DACL_BYTE_L: begin
        r.hi = (s == 2'h0);
        r.mid = (s == 2'h0);
        r.lo = (s == 2'h1);
        r.load = (s == 2'h1) && !defer;
        r.last = (s == 2'h1);
      end
      // one strobe into the converter latch
      DACL_WIDE: begin
        r.load = !defer;
        r.last = 1'b1;
      end
      default: r.last = 1'b1;
    endcase
    return r;
  endfunction : step_ctl

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_WRITE
  } dacl_state_e;

  dacl_state_e state_r;
  dacl_cmd_s cmd_r;
  dacl_mode_e mode_r;
  logic [1:0] step_r;
  logic start_r;
  logic done;
  dacl_step_s cur;
  logic [NUM_DAC-1:0] sel;
  logic all_load;

  assign cur = step_ctl(mode_r, step_r, cmd_r.defer);
  assign sel = NUM_DAC'(1) << cmd_r.chan;
  // last converter's low write drives every transfer
  assign all_load = last_loads_all && cur.lo && (cmd_r.chan == 4'(NUM_DAC - 1));

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
      mode_r <= DACL_NIB4;
      step_r <= 2'h0;
      start_r <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          mode_r <= mode;
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_r <= cmd;
            step_r <= 2'h0;
            cmd_ready <= 1'b0;
            state_r <= ST_ARM;
          end
        end
        ST_ARM: begin
          start_r <= 1'b1;
          state_r <= ST_WRITE;
        end
        ST_WRITE: begin
          if (done) begin
            if (cmd_r.update_all || cur.last) begin
              state_r <= ST_IDLE;
            end else begin
              // further write of the same code
              step_r <= step_r + 2'h1;
              state_r <= ST_ARM;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // latch selects and data pins
  // ****************************************
  // selects are set DACL_SETUP_CYC + 1 cycles ahead of the strobe and dropped after its hold,
  // so the device never sees a select change while its strobe is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nib_hi_n <= '1;
      nib_mid_n <= '1;
      nib_lo_n <= '1;
      converter_latch_load_n <= '1;
      dac_data <= DACL_CODE_RST;
    end else begin
      if (state_r == ST_ARM) begin
        dac_data <= cmd_r.code;
        if (cmd_r.update_all) begin
          converter_latch_load_n <= '0;
        end else begin
          // several selects may open in one write
          nib_hi_n <= cur.hi ? ~sel : '1;
          nib_mid_n <= cur.mid ? ~sel : '1;
          nib_lo_n <= cur.lo ? ~sel : '1;
          // deferred codes wait for a shared transfer
          converter_latch_load_n <= all_load ? '0 : (cur.load ? ~sel : '1);
        end
      end else if (state_r == ST_WRITE && done) begin
        nib_hi_n <= '1;
        nib_mid_n <= '1;
        nib_lo_n <= '1;
        converter_latch_load_n <= '1;
      end
      // wide bus keeps the input latches transparent
      if (mode_r == DACL_WIDE) begin
        nib_hi_n <= '0;
        nib_mid_n <= '0;
        nib_lo_n <= '0;
      end
    end
  end

  // strobe while a select is decoded, except when cmd.chan is NUM_DAC or above and no select opens
  // strobe flop drives the pin with no gating
  dacl_strobe u_strobe (
    .clk(clk),
    .reset(reset),
    .start(start_r),
    .wr_n(wr_n),
    .done(done)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] low_cnt_r;
  logic [2:0] wr_cnt_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= 8'h00;
      wr_cnt_r <= 3'h0;
    end else begin
      low_cnt_r <= wr_n ? 8'h00 : low_cnt_r + 8'h01;
      if (state_r == ST_IDLE) begin
        wr_cnt_r <= 3'h0;
      end else if ($fell(wr_n)) begin
        wr_cnt_r <= wr_cnt_r + 3'h1;
      end
    end
  end

  property p_strobe_decoded;
    !wr_n |-> (~&converter_latch_load_n || (mode_r != DACL_WIDE && (~&nib_hi_n || ~&nib_mid_n || ~&nib_lo_n)));
  endproperty
  a_strobe_decoded: assert property (p_strobe_decoded) else $error("strobe low with no select");

  property p_sel_stable;
    !wr_n && !$past(wr_n) |-> $stable(nib_hi_n) && $stable(nib_mid_n) && $stable(nib_lo_n)
      && $stable(converter_latch_load_n);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select moved during strobe");

  property p_low_width;
    $rose(wr_n) |-> low_cnt_r == 8'(DACL_WR_LOW_CYC);
  endproperty
  a_low_width: assert property (p_low_width) else $error("strobe low width wrong");

  property p_nib4_single;
    !wr_n && mode_r == DACL_NIB4 && !cmd_r.update_all |->
      $countones({~nib_hi_n, ~nib_mid_n, ~nib_lo_n, ~converter_latch_load_n}) == 1;
  endproperty
  a_nib4_single: assert property (p_nib4_single) else $error("nibble bus write not one slot");

  property p_byte_two_writes;
    (mode_r == DACL_BYTE_R || mode_r == DACL_BYTE_L) && !cmd_r.update_all && state_r == ST_WRITE && done
      && cur.last |-> wr_cnt_r == 3'h2;
  endproperty
  a_byte_two_writes: assert property (p_byte_two_writes) else $error("byte code not two writes");

  property p_right_low_byte;
    !wr_n && mode_r == DACL_BYTE_R && ~&nib_lo_n |-> nib_lo_n == nib_mid_n && &nib_hi_n && &converter_latch_load_n;
  endproperty
  a_right_low_byte: assert property (p_right_low_byte) else $error("right low byte selects wrong");

  property p_left_high_byte;
    !wr_n && mode_r == DACL_BYTE_L && ~&nib_hi_n |-> nib_hi_n == nib_mid_n && &nib_lo_n;
  endproperty
  a_left_high_byte: assert property (p_left_high_byte) else $error("left high byte selects wrong");

  property p_one_converter;
    !wr_n && !cmd_r.update_all |-> $onehot0(~nib_hi_n) && $onehot0(~nib_lo_n) || mode_r == DACL_WIDE;
  endproperty
  a_one_converter: assert property (p_one_converter) else $error("two converters selected");

  property p_update_all;
    !wr_n && cmd_r.update_all |-> converter_latch_load_n == '0;
  endproperty
  a_update_all: assert property (p_update_all) else $error("shared transfer missed a converter");

  property p_wide_open;
    mode_r == DACL_WIDE && state_r != ST_IDLE |-> nib_hi_n == '0 && nib_mid_n == '0 && nib_lo_n == '0;
  endproperty
  a_wide_open: assert property (p_wide_open) else $error("wide bus enables not low");

  property p_wide_single;
    mode_r == DACL_WIDE && state_r == ST_WRITE && done |-> wr_cnt_r == 3'h1;
  endproperty
  a_wide_single: assert property (p_wide_single) else $error("wide write not single strobe");

  c_nib4: cover property (mode_r == DACL_NIB4 && state_r == ST_WRITE && done && cur.load);
  c_byte_r: cover property (mode_r == DACL_BYTE_R && !wr_n && ~&converter_latch_load_n);
  c_byte_l: cover property (mode_r == DACL_BYTE_L && !wr_n && ~&converter_latch_load_n);
  c_all: cover property (cmd_r.update_all && !wr_n);

endmodule : dacl_host

// ---- dacl_conv_model.sv ----
// behavioural model of one double-buffered converter latch port
module dacl_conv_model
  import dacl_pkg::*;
(
  input wire logic wr_n,
  input wire logic hi_n,
  input wire logic mid_n,
  input wire logic lo_n,
  input wire logic load_n,
  input wire logic [DACL_CODE_W-1:0] data,
  output logic [DACL_CODE_W-1:0] dac_out
);
  // ****************************************
  // latches
  // ****************************************
  // no reset: contents stay unknown until loaded
  // unknown until loaded
  logic [DACL_CODE_W-1:0] in_r;
  always_latch begin
    if (!(wr_n | hi_n)) in_r[11:8] = data[11:8];
    if (!(wr_n | mid_n)) in_r[7:4] = data[7:4];
    if (!(wr_n | lo_n)) in_r[3:0] = data[3:0];
  end
  always_latch begin
    if (!(wr_n | load_n)) dac_out = in_r;
  end
endmodule : dacl_conv_model

// ---- tb.sv ----
// self-checking bench for the converter latch port host
module tb
  import dacl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 4;
  logic clk = 0;
  logic reset = 1;
  dacl_mode_e mode = DACL_BYTE_R;
  logic last_loads_all = 0;
  logic cmd_valid = 0;
  dacl_cmd_s cmd = '0;
  logic cmd_ready, wr_n;
  logic [11:0] dac_data;
  logic [N-1:0] nib_hi_n, nib_mid_n, nib_lo_n, converter_latch_load_n;
  logic [11:0] dac_out [N];
  int miscompares = 0;
  int comparisons = 0;
  int writes = 0;
  int low = 0;
  always #2 clk = ~clk;
  dacl_host #(.NUM_DAC(N)) dut (.clk(clk), .reset(reset), .mode(mode),
    .last_loads_all(last_loads_all), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .dac_data(dac_data), .wr_n(wr_n), .nib_hi_n(nib_hi_n),
    .nib_mid_n(nib_mid_n), .nib_lo_n(nib_lo_n), .converter_latch_load_n(converter_latch_load_n));
  for (genvar g = 0; g < N; g++) begin : g_dac
    dacl_conv_model u_m (.wr_n(wr_n), .hi_n(nib_hi_n[g]), .mid_n(nib_mid_n[g]),
      .lo_n(nib_lo_n[g]), .load_n(converter_latch_load_n[g]), .data(dac_data),
      .dac_out(dac_out[g]));
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  // counts strobes and measures each low phase
  always @(negedge clk) begin
    if (!reset && wr_n === 1'b0) begin
      low++;
    end else if (low != 0) begin
      chk(12'(low), 12'(DACL_WR_LOW_CYC));
      writes++;
      low = 0;
    end
  end
  task automatic wait_ready();
    int i;
    for (i = 0; i < 300 && cmd_ready !== 1'b1; i++) begin
      @(posedge clk) #1;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_ready
  // a busy host must ignore the altered request that follows acceptance
  task automatic run(input dacl_mode_e m, input logic ua, input logic df,
                     input logic [3:0] ch, input logic [11:0] cd, input int nw);
    mode = m;
    @(posedge clk) #1;
    wait_ready();
    writes = 0;
    cmd_valid = 1;
    cmd = '{ua, df, ch, cd};
    @(posedge clk) #1;
    cmd.code = ~cd;
    repeat (5) @(posedge clk);
    #1 cmd_valid = 0;
    wait_ready();
    chk(12'(writes), 12'(nw));
  endtask : run
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_byte_r();
    run(DACL_BYTE_R, 0, 0, 1, 12'hA5C, 2);
    chk(dac_out[1], 12'hA5C);
    $display("byte right done");
  endtask : t_byte_r
  task automatic t_byte_l();
    run(DACL_BYTE_L, 0, 0, 2, 12'h3C7, 2);
    chk(dac_out[2], 12'h3C7);
    $display("byte left done");
  endtask : t_byte_l
  // deferred nibble code must stay in the input latches only
  task automatic t_nib4();
    run(DACL_NIB4, 0, 0, 0, 12'h9E1, 4);
    chk(dac_out[0], 12'h9E1);
    run(DACL_NIB4, 0, 1, 2, 12'h5A5, 3);
    chk(dac_out[2], 12'h3C7);
    $display("nibble done");
  endtask : t_nib4
  task automatic t_shared();
    run(DACL_BYTE_R, 0, 1, 0, 12'h123, 2);
    run(DACL_BYTE_R, 0, 1, 3, 12'hFED, 2);
    chk(dac_out[0], 12'h9E1);
    run(DACL_BYTE_R, 1, 0, 0, 12'h000, 1);
    chk(dac_out[0], 12'h123);
    chk(dac_out[3], 12'hFED);
    chk(dac_out[2], 12'h5A5);
    chk(dac_out[1], 12'hA5C);
    $display("shared update done");
  endtask : t_shared
  task automatic t_last();
    last_loads_all = 1;
    run(DACL_BYTE_L, 0, 1, 0, 12'h456, 2);
    chk(dac_out[0], 12'h123);
    run(DACL_BYTE_L, 0, 1, 3, 12'h789, 2);
    chk(dac_out[0], 12'h456);
    chk(dac_out[3], 12'h789);
    last_loads_all = 0;
    $display("last loads all done");
  endtask : t_last
  task automatic t_wide();
    run(DACL_WIDE, 0, 0, 2, 12'hB0D, 1);
    chk(dac_out[2], 12'hB0D);
    chk({nib_hi_n, nib_mid_n, nib_lo_n}, 12'h000);
    run(DACL_WIDE, 0, 0, 1, 12'h0F0, 1);
    chk(dac_out[1], 12'h0F0);
    $display("wide done");
  endtask : t_wide
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk({11'h000, wr_n}, 12'h001);
    reset = 0;
    t_byte_r();
    t_byte_l();
    t_nib4();
    t_shared();
    t_last();
    t_wide();
    finish_test();
  end
endmodule : tb
